// File: ftw_params.svh
// Overview of operation
// - gate fixed oscillator per tach period, saturating
// - fan divisor resets to two; 1/2/4/8
// - each fan has its own divisor field
// - fan input may act as level input
// - count equals 1.35e6 over rpm times divisor
// - temperature result nine or twelve bits
// - eight-bit compare against setpoints and hysteresis
// - four setpoints at 38h-3Bh, read/write
// - default reading nine bits, half degree step
// - twelve-bit reading, sixteenth degree step
// - high byte at 27h, low bits config 7-4
// - nine-bit mode: only config bit 7 valid
// - four limits drive interrupt and overtemp outputs
// - overtemp: one-time/comparator; interrupt: default/one-time
// - above hot limit interrupt holds until cleared
// - default mode re-raises while above hysteresis
// - default mode clears below hot hysteresis
// - one-time mode rearms only below hysteresis
// - comparator drives overtemp low above limit
// - status read clears latched interrupt outputs
// - config bit 2 selects overtemp output mode
// - clear bit drops interrupt, halts monitoring
`ifndef FTW_PARAMS_SVH
`define FTW_PARAMS_SVH

// ==========================================================
// register addresses
`define FTW_ADDR_CFG      8'h00
`define FTW_ADDR_ISR1     8'h01
`define FTW_ADDR_ISR2     8'h02
`define FTW_ADDR_FANDIV   8'h05
`define FTW_ADDR_TCFG     8'h06
`define FTW_ADDR_TEMP     8'h27
`define FTW_ADDR_TACH_INPUT_FIRST     8'h28
`define FTW_ADDR_TACH_INPUT_SECOND     8'h29
`define FTW_ADDR_LIM_HI6  6'h0E
// ==========================================================
// field positions
`define FTW_CFG_START     0
`define FTW_CFG_INT_EN    1
`define FTW_CFG_INT_CLR   3
`define FTW_ISR1_HOT      6
`define FTW_ISR2_OS       5
`define FTW_FD_LVL1       0
`define FTW_FD_LVL2       1
`define FTW_FD_OS_EN      6
`define FTW_FD_RST_EN     7
`define FTW_TC_ONE_TIME   1
`define FTW_TC_OS_ONE     2
`define FTW_TC_RES12      3
// ==========================================================
// reset values
`define FTW_CFG_RST       8'h08
`define FTW_FANDIV_RST    8'h14
`define FTW_TCFG_RST      4'h0
`define FTW_LIM_RST       8'h00
// ==========================================================
// timing
`define FTW_CLK_HZ        20000000
`define FTW_OSC_HZ        22500
`define FTW_TICK_CYC      (`FTW_CLK_HZ / (2 * `FTW_OSC_HZ))

`endif

// File: ftw_pkg.sv
// ==========================================================
// shared types
package ftw_pkg;
   typedef logic [7:0]  ftw_byte_t;   // one register byte
   typedef logic [11:0] ftw_temp_t;   // raw sample, 1/16 degree
   typedef logic [1:0]  ftw_div_t;    // divisor code, value 1<<code
endpackage

// File: ftw_fan_meter.sv
`timescale 1ns/1ps
`include "ftw_params.svh"
module ftw_fan_meter (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // timing and control
   input  wire logic             osc_tick,   // double-rate oscillator pulse
   input  wire logic             run,        // monitoring loop active
   input  wire ftw_pkg::ftw_div_t div_sel,   // divisor code
   input  wire logic             level_mode, // digital input instead of tach
   // fan
   input  wire logic             tach,
   // result
   output ftw_pkg::ftw_byte_t    reading_r
);
   import ftw_pkg::*;

   // ==========================================================
   // state
   logic      tach_d_r, tach_d_nxt;        // previous tach level
   logic [2:0] pre_r, pre_nxt;             // divisor prescaler
   ftw_byte_t cnt_r, cnt_nxt;              // period counter
   ftw_byte_t reading_nxt;

   logic [2:0] div_last;                   // last prescaler state
   logic       gate;                       // gated oscillator pulse
   logic       period_edge;                // start of a new tach period

   // ==========================================================
   // next state
   always_comb begin
      div_last    = 3'((4'h1 << div_sel) - 4'h1);
      gate        = osc_tick && (pre_r == div_last);
      period_edge = tach && !tach_d_r;
      tach_d_nxt  = tach;
      pre_nxt     = pre_r;
      cnt_nxt     = cnt_r;
      reading_nxt = reading_r;
      // prescaler: count = 1.35e6/(rpm*div)
      if (osc_tick) begin
         pre_nxt = (pre_r == div_last) ? 3'h0 : 3'(pre_r + 3'h1);
      end
      if (level_mode) begin
         // level mode: pin in bit 0
         reading_nxt = {7'h00, tach};
         cnt_nxt     = 8'h00;
      end else if (run) begin
         if (period_edge) begin
            reading_nxt = cnt_r;
            cnt_nxt     = 8'h00;
         end else if (gate && cnt_r != 8'hFF) begin
            cnt_nxt = 8'(cnt_r + 8'h01);
         end
         // stalled fan shows full scale at once
         if (!period_edge && cnt_r == 8'hFF) begin
            reading_nxt = 8'hFF;
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tach_d_r  <= 1'b0;
         pre_r     <= 3'h0;
         cnt_r     <= 8'h00;
         reading_r <= 8'h00;
      end else begin
         tach_d_r  <= tach_d_nxt;
         pre_r     <= pre_nxt;
         cnt_r     <= cnt_nxt;
         reading_r <= reading_nxt;
      end
   end
endmodule

// File: ftw_top.sv
`timescale 1ns/1ps
`include "ftw_params.svh"
module ftw_top #(
   parameter int TICK_CYC = `FTW_TICK_CYC  // clocks per double-rate oscillator tick
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // register port
   input  wire ftw_pkg::ftw_byte_t reg_addr,
   input  wire logic               reg_wr,
   input  wire ftw_pkg::ftw_byte_t reg_wdata,
   input  wire logic               reg_rd,
   output ftw_pkg::ftw_byte_t      reg_rdata_r,
   // fans
   input  wire logic               tach_input_first,
   input  wire logic               tach_input_second,
   // temperature converter
   input  wire ftw_pkg::ftw_temp_t temp_sample,
   input  wire logic               temp_done,
   // interrupt output, active high level
   output logic                    int_out_r,
   // open-drain overtemp pin
   input  wire logic               reset_or_overtemp_pin_i,
   output logic                    reset_or_overtemp_pin_o_r,
   output logic                    reset_or_overtemp_pin_oe_r
);
   import ftw_pkg::*;

   // ==========================================================
   // one watchdog step, returns {flag, episode}
   // the episode bit remembers a crossing until the reading drops below
   // hysteresis; default mode re-raises inside the band, one-time does not
   function automatic logic [1:0] watch_step(
      input logic      one_time,
      input logic      flag,
      input logic      epi,
      input ftw_byte_t t,
      input ftw_byte_t lim,
      input ftw_byte_t hyst
   );
      logic f;
      logic e;
      f = flag;
      e = epi;
      if ($signed(t) < $signed(hyst)) begin
         e = 1'b0;
         if (!one_time) begin
            f = 1'b0;
         end
      end else if ($signed(t) > $signed(lim)) begin
         if (!one_time || !e) begin
            f = 1'b1;
         end
         e = 1'b1;
      end else if (e && !one_time) begin
         f = 1'b1;
      end
      return {f, e};
   endfunction

   // ==========================================================
   // control registers
   ftw_byte_t  cfg_r, cfg_nxt;              // start, int enable, int clear
   ftw_byte_t  fandiv_r, fandiv_nxt;        // divisors, level modes, os enable
   logic [3:0] tcfg_r, tcfg_nxt;            // writable low nibble
   ftw_byte_t  lim_r   [0:3];               // hot, hot hyst, os, os hyst
   ftw_byte_t  lim_nxt [0:3];

   // ==========================================================
   // temperature state
   ftw_byte_t  temp_hi_r, temp_hi_nxt;      // eight msbs of reading
   logic [3:0] temp_lo_r, temp_lo_nxt;      // fraction bits
   logic       hot_flag_r, hot_flag_nxt;    // hot status bit
   logic       hot_epi_r, hot_epi_nxt;
   logic       osb_flag_r, osb_flag_nxt;    // overtemp status bit
   logic       osb_epi_r, osb_epi_nxt;
   logic       osp_flag_r, osp_flag_nxt;    // overtemp pin, one-time mode
   logic       osp_epi_r, osp_epi_nxt;
   logic       osc_act_r, osc_act_nxt;      // overtemp pin, comparator mode

   // ==========================================================
   // outputs and oscillator
   ftw_byte_t  rdata_nxt;
   logic       int_nxt;
   logic       os_oe_nxt;
   logic [9:0] tick_cnt_r, tick_cnt_nxt;    // oscillator divider
   logic       osc_tick_r, osc_tick_nxt;

   // ==========================================================
   // decoded signals
   logic       run;                         // monitoring loop active
   logic       conv;                        // accepted conversion
   logic       rd_isr1, rd_isr2;            // status reads that clear
   logic       lim_sel;                     // setpoint address
   ftw_byte_t  tach_input_first_reading, tach_input_second_reading;
   ftw_byte_t  t_new;                       // high byte of incoming sample
   logic [1:0] st;

   // clear bit halts the loop, status kept
   assign run     = cfg_r[`FTW_CFG_START] && !cfg_r[`FTW_CFG_INT_CLR];
   assign conv    = temp_done && run;
   assign rd_isr1 = reg_rd && (reg_addr == `FTW_ADDR_ISR1);
   assign rd_isr2 = reg_rd && (reg_addr == `FTW_ADDR_ISR2);
   assign lim_sel = (reg_addr[7:2] == `FTW_ADDR_LIM_HI6);
   assign t_new   = temp_sample[11:4];

   // ==========================================================
   // oscillator runs at twice the nominal rate so that
   // the default divide-by-two gives nominal counts
   always_comb begin
      osc_tick_nxt = 1'b0;
      tick_cnt_nxt = 10'(tick_cnt_r + 10'h001);
      if (tick_cnt_r == 10'(TICK_CYC - 1)) begin
         tick_cnt_nxt = 10'h000;
         osc_tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_r <= 10'h000;
         osc_tick_r <= 1'b0;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         osc_tick_r <= osc_tick_nxt;
      end
   end

   // ==========================================================
   // fan meters
   ftw_fan_meter u_tach_input_first (
      .clk        (clk),
      .rst_b      (rst_b),
      .osc_tick   (osc_tick_r),
      .run        (run),
      .div_sel    (fandiv_r[3:2]),
      .level_mode (fandiv_r[`FTW_FD_LVL1]),
      .tach       (tach_input_first),
      .reading_r  (tach_input_first_reading)
   );

   ftw_fan_meter u_tach_input_second (
      .clk        (clk),
      .rst_b      (rst_b),
      .osc_tick   (osc_tick_r),
      .run        (run),
      .div_sel    (fandiv_r[5:4]),
      .level_mode (fandiv_r[`FTW_FD_LVL2]),
      .tach       (tach_input_second),
      .reading_r  (tach_input_second_reading)
   );

   // ==========================================================
   // register writes
   always_comb begin
      cfg_nxt    = cfg_r;
      fandiv_nxt = fandiv_r;
      tcfg_nxt   = tcfg_r;
      for (int i = 0; i < 4; i++) begin
         lim_nxt[i] = lim_r[i];
      end
      if (reg_wr) begin
         if (reg_addr == `FTW_ADDR_CFG) begin
            cfg_nxt = {1'b0, reg_wdata[6:0]};
         end
         if (reg_addr == `FTW_ADDR_FANDIV) begin
            fandiv_nxt = reg_wdata;
         end
         if (reg_addr == `FTW_ADDR_TCFG) begin
            // bits 7-4 are read-only data
            tcfg_nxt = reg_wdata[3:0];
         end
         if (lim_sel) begin
            lim_nxt[reg_addr[1:0]] = reg_wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r    <= `FTW_CFG_RST;
         fandiv_r <= `FTW_FANDIV_RST;
         tcfg_r   <= `FTW_TCFG_RST;
         for (int i = 0; i < 4; i++) begin
            lim_r[i] <= `FTW_LIM_RST;
         end
      end else begin
         cfg_r    <= cfg_nxt;
         fandiv_r <= fandiv_nxt;
         tcfg_r   <= tcfg_nxt;
         for (int i = 0; i < 4; i++) begin
            lim_r[i] <= lim_nxt[i];
         end
      end
   end

   // ==========================================================
   // temperature capture and watchdog
   // status read clears first; the same cycle's conversion
   // steps from the cleared value, so a new event survives
   always_comb begin
      temp_hi_nxt  = temp_hi_r;
      temp_lo_nxt  = temp_lo_r;
      hot_flag_nxt = rd_isr1 ? 1'b0 : hot_flag_r;
      hot_epi_nxt  = hot_epi_r;
      osb_flag_nxt = rd_isr2 ? 1'b0 : osb_flag_r;
      osb_epi_nxt  = osb_epi_r;
      osp_flag_nxt = rd_isr2 ? 1'b0 : osp_flag_r;
      osp_epi_nxt  = osp_epi_r;
      osc_act_nxt  = osc_act_r;
      st           = 2'b00;
      if (conv) begin
         temp_hi_nxt = t_new;
         if (tcfg_r[`FTW_TC_RES12]) begin
            temp_lo_nxt = temp_sample[3:0];
         end else begin
            // half degree in bit 7, rest zero
            temp_lo_nxt = {temp_sample[3], 3'b000};
         end
         // comparator sees the eight msbs
         st = watch_step(tcfg_r[`FTW_TC_ONE_TIME], hot_flag_nxt, hot_epi_r,
                         t_new, lim_r[0], lim_r[1]);
         hot_flag_nxt = st[1];
         hot_epi_nxt  = st[0];
         st = watch_step(tcfg_r[`FTW_TC_ONE_TIME], osb_flag_nxt, osb_epi_r,
                         t_new, lim_r[2], lim_r[3]);
         osb_flag_nxt = st[1];
         osb_epi_nxt  = st[0];
         st = watch_step(1'b1, osp_flag_nxt, osp_epi_r,
                         t_new, lim_r[2], lim_r[3]);
         osp_flag_nxt = st[1];
         osp_epi_nxt  = st[0];
         // equal reading holds the comparator state
         if ($signed(t_new) > $signed(lim_r[2])) begin
            osc_act_nxt = 1'b1;
         end else if ($signed(t_new) < $signed(lim_r[2])) begin
            osc_act_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         temp_hi_r  <= 8'h00;
         temp_lo_r  <= 4'h0;
         hot_flag_r <= 1'b0;
         hot_epi_r  <= 1'b0;
         osb_flag_r <= 1'b0;
         osb_epi_r  <= 1'b0;
         osp_flag_r <= 1'b0;
         osp_epi_r  <= 1'b0;
         osc_act_r  <= 1'b0;
      end else begin
         temp_hi_r  <= temp_hi_nxt;
         temp_lo_r  <= temp_lo_nxt;
         hot_flag_r <= hot_flag_nxt;
         hot_epi_r  <= hot_epi_nxt;
         osb_flag_r <= osb_flag_nxt;
         osb_epi_r  <= osb_epi_nxt;
         osp_flag_r <= osp_flag_nxt;
         osp_epi_r  <= osp_epi_nxt;
         osc_act_r  <= osc_act_nxt;
      end
   end

   // ==========================================================
   // read mux and output pins
   always_comb begin
      rdata_nxt = reg_rdata_r;
      if (reg_rd) begin
         unique case (reg_addr)
            `FTW_ADDR_CFG:    rdata_nxt = cfg_r;
            `FTW_ADDR_ISR1:   rdata_nxt = 8'(hot_flag_r) << `FTW_ISR1_HOT;
            `FTW_ADDR_ISR2:   rdata_nxt = 8'(osb_flag_r) << `FTW_ISR2_OS;
            `FTW_ADDR_FANDIV: rdata_nxt = fandiv_r;
            `FTW_ADDR_TCFG:   rdata_nxt = {temp_lo_r, tcfg_r};
            `FTW_ADDR_TEMP:   rdata_nxt = temp_hi_r;
            `FTW_ADDR_TACH_INPUT_FIRST:   rdata_nxt = tach_input_first_reading;
            `FTW_ADDR_TACH_INPUT_SECOND:   rdata_nxt = tach_input_second_reading;
            default: begin
               // setpoints, else zero
               rdata_nxt = lim_sel ? lim_r[reg_addr[1:0]] : 8'h00;
            end
         endcase
      end
      // clear bit forces the line low
      int_nxt = cfg_r[`FTW_CFG_INT_EN] && !cfg_r[`FTW_CFG_INT_CLR]
                && (hot_flag_nxt || osb_flag_nxt);
      // pin needs os enable, reset off
      os_oe_nxt = fandiv_r[`FTW_FD_OS_EN] && !fandiv_r[`FTW_FD_RST_EN]
                  && !cfg_r[`FTW_CFG_INT_CLR]
                  && (tcfg_r[`FTW_TC_OS_ONE] ? osp_flag_nxt : osc_act_nxt);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_r                <= 8'h00;
         int_out_r                  <= 1'b0;
         reset_or_overtemp_pin_o_r  <= 1'b0;
         reset_or_overtemp_pin_oe_r <= 1'b0;
      end else begin
         reg_rdata_r                <= rdata_nxt;
         int_out_r                  <= int_nxt;
         reset_or_overtemp_pin_o_r  <= 1'b0;          // open drain pulls low only
         reset_or_overtemp_pin_oe_r <= os_oe_nxt;
      end
   end
endmodule

// File: ftw_asserts.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module ftw_asserts (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // register port
   input  wire ftw_pkg::ftw_byte_t reg_addr,
   input  wire logic               reg_wr,
   input  wire ftw_pkg::ftw_byte_t reg_wdata,
   input  wire logic               reg_rd,
   input  wire ftw_pkg::ftw_byte_t reg_rdata_r,
   // converter and outputs
   input  wire ftw_pkg::ftw_temp_t temp_sample,
   input  wire logic               temp_done,
   input  wire logic               int_out_r,
   input  wire logic               reset_or_overtemp_pin_o_r,
   input  wire logic               reset_or_overtemp_pin_oe_r
);
   import ftw_pkg::*;
   ftw_byte_t cfg_r, cfg_nxt; // control register mirror
   ftw_byte_t hi_r, hi_nxt;   // last accepted high byte
   logic      res_r, res_nxt; // twelve-bit mode mirror
   logic      fdw_r, fdw_nxt; // divisor register has been written
   // ==========================================================
   // mirrors; conversions only while running
   always_comb begin
      cfg_nxt = (reg_wr && reg_addr == 8'h00) ? reg_wdata : cfg_r;
      res_nxt = (reg_wr && reg_addr == 8'h06) ? reg_wdata[3] : res_r;
      fdw_nxt = fdw_r | (reg_wr && reg_addr == 8'h05);
      hi_nxt  = (temp_done && cfg_r[0] && !cfg_r[3]) ? temp_sample[11:4] : hi_r;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= 8'h08;
         hi_r  <= 8'h00;
         res_r <= 1'b0;
         fdw_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         hi_r  <= hi_nxt;
         res_r <= res_nxt;
         fdw_r <= fdw_nxt;
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_isr_pair;
      reg_rd && reg_addr == 8'h01 && !temp_done ##1 reg_rd && reg_addr == 8'h02 && !temp_done;
   endsequence
   sequence s_hot_wr;
      reg_wr && reg_addr == 8'h38 && !reg_rd;
   endsequence
   property p_clr_drop;
      reg_wr && reg_addr == 8'h00 && reg_wdata[3] && !temp_done
         |=> ##1 (!int_out_r && !reset_or_overtemp_pin_oe_r);
   endproperty
   a_clr_drop: assert property (p_clr_drop) else $error("clear left an output on");
   property p_isr_pair;
      s_isr_pair |=> !int_out_r;
   endproperty
   a_isr_pair: assert property (p_isr_pair) else $error("status reads kept int");
   property p_int_cause;
      $rose(int_out_r) |-> $past(temp_done) || $past(reg_wr, 2);
   endproperty
   a_int_cause: assert property (p_int_cause) else $error("int rose uncaused");
   property p_pin_cause;
      $rose(reset_or_overtemp_pin_oe_r) |-> $past(temp_done) || $past(reg_wr, 2);
   endproperty
   a_pin_cause: assert property (p_pin_cause) else $error("pin pulled uncaused");
   property p_hot_back;
      s_hot_wr ##1 (reg_rd && reg_addr == 8'h38) |=> reg_rdata_r == $past(reg_wdata, 2);
   endproperty
   a_hot_back: assert property (p_hot_back) else $error("setpoint readback wrong");
   property p_temp_hi;
      reg_rd && reg_addr == 8'h27 && !temp_done |=> reg_rdata_r == hi_r;
   endproperty
   a_temp_hi: assert property (p_temp_hi) else $error("high byte wrong");
   property p_div_reset;
      reg_rd && reg_addr == 8'h05 && !reg_wr && !fdw_r |=> reg_rdata_r == 8'h14;
   endproperty
   a_div_reset: assert property (p_div_reset) else $error("divisor reset wrong");
   property p_frac_9;
      reg_rd && reg_addr == 8'h06 && !reg_wr && !res_r |=> reg_rdata_r[6:4] == 3'h0;
   endproperty
   a_frac_9: assert property (p_frac_9) else $error("nine-bit fraction junk");
endmodule

bind ftw_top ftw_asserts chk_u (.*);

// File: ftw_far_model.sv
`timescale 1ns/1ps
// ==========================================================
// far side: fans and converter
module ftw_far_model (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // bench controls
   input  wire logic               spin,        // fans rotating
   input  wire logic [15:0]        half_first,  // half tach period, clocks
   input  wire logic [15:0]        half_second,
   input  wire logic               lvl_first,   // level while not spinning
   input  wire logic               lvl_second,
   input  wire logic               conv_go,     // finish one conversion
   input  wire ftw_pkg::ftw_temp_t conv_val,
   // toward the block
   output logic                    tach_first,
   output logic                    tach_second,
   output ftw_pkg::ftw_temp_t      temp_sample,
   output logic                    temp_done
);
   import ftw_pkg::*;
   logic [15:0] cnt1_r, cnt2_r; // half period counters
   ftw_temp_t   last_r;         // last value put on the result bus
   // two pulses per turn
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt1_r      <= 16'h0000;
         cnt2_r      <= 16'h0000;
         tach_first  <= 1'b0;
         tach_second <= 1'b0;
         temp_done   <= 1'b0;
         temp_sample <= 12'h000;
         last_r      <= 12'h000;
      end else begin
         // bus carries junk outside the pulse
         temp_done   <= conv_go;
         temp_sample <= conv_go ? conv_val : ~last_r;
         if (conv_go) begin
            last_r <= conv_val;
         end
         cnt1_r <= (!spin || cnt1_r >= half_first - 16'h0001) ? 16'h0000 : cnt1_r + 16'h0001;
         cnt2_r <= (!spin || cnt2_r >= half_second - 16'h0001) ? 16'h0000 : cnt2_r + 16'h0001;
         // stopped fan: static level
         tach_first  <= !spin ? lvl_first : (cnt1_r >= half_first - 16'h0001) ^ tach_first;
         tach_second <= !spin ? lvl_second : (cnt2_r >= half_second - 16'h0001) ^ tach_second;
      end
   end
endmodule

// File: tb_fan_tach_and_temp_watchdog.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench
module tb_fan_tach_and_temp_watchdog;
   import ftw_pkg::*;
   localparam int TICK  = 4;     // short tick, brief run
   localparam int LIMIT = 20000; // run ceiling
   logic        clk, rst_b, reg_wr, reg_rd, int_out_r, pin_o, pin_oe;
   logic        tach_first, tach_second, temp_done, spin, lvl_first, lvl_second, conv_go;
   ftw_byte_t   reg_addr, reg_wdata, reg_rdata_r, d1, d2;
   ftw_temp_t   temp_sample, conv_val;
   logic [15:0] half_first, half_second;
   int          n_fail, checked, cycles;
   ftw_byte_t   lim_v [4] = '{8'h32, 8'h2D, 8'h3C, 8'h37}; // hot, hyst, os, os hyst
   // pull-up on the pin
   ftw_top #(.TICK_CYC(TICK)) dut_u (.*, .tach_input_first(tach_first),
      .tach_input_second(tach_second), .reset_or_overtemp_pin_i(!pin_oe),
      .reset_or_overtemp_pin_o_r(pin_o), .reset_or_overtemp_pin_oe_r(pin_oe));
   ftw_far_model far_u (.*);
   // ==========================================================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_fail++;
         $display("CHECK FAILED at %0t: run hung", $time);
         wrap_up();
      end
   end
   // ==========================================================
   // compare tasks
   task automatic chk8(input ftw_byte_t got, input ftw_byte_t exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: byte %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: bit %b, wanted %b", $time, got, exp);
      end
   endtask
   task automatic chkr(input ftw_byte_t got, input int lo, input int hi);
      checked++;
      if ($isunknown(got) || got < lo || got > hi) begin
         n_fail++;
         $display("CHECK FAILED at %0t: count %0d, wanted %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================================
   // register tasks, falling edge to falling edge
   task automatic wr(input ftw_byte_t a, input ftw_byte_t d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask
   // write, read back next cycle
   task automatic wr_chk(input ftw_byte_t a, input ftw_byte_t d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      rdc(a, d);
   endtask
   task automatic rd(input ftw_byte_t a, output ftw_byte_t d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      d = reg_rdata_r;
      reg_rd = 1'b0;
      @(negedge clk);
   endtask
   // both status registers back to back
   task automatic rd2(output ftw_byte_t s1, output ftw_byte_t s2);
      reg_addr = 8'h01;
      reg_rd = 1'b1;
      @(negedge clk);
      s1 = reg_rdata_r;
      reg_addr = 8'h02;
      @(negedge clk);
      s2 = reg_rdata_r;
      reg_rd = 1'b0;
      @(negedge clk);
   endtask
   task automatic rdc(input ftw_byte_t a, input ftw_byte_t exp);
      ftw_byte_t d;
      rd(a, d);
      chk8(d, exp);
   endtask
   // one conversion, then settle
   task automatic conv(input ftw_temp_t v);
      conv_val = v;
      conv_go = 1'b1;
      @(negedge clk);
      conv_go = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, conv_go, spin, lvl_first, lvl_second} = '0;
      half_first = 16'h00C8;
      half_second = 16'h00C8;
      conv_val = 12'h000;
      {n_fail, checked, cycles} = '0;
      rst_b = 1'b0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      rdc(8'h00, 8'h08);
      rdc(8'h05, 8'h14);
      rdc(8'h06, 8'h00);
      rdc(8'h7F, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rdc(8'h38 + 8'(i), 8'h00);
         wr_chk(8'h38 + 8'(i), lim_v[i]);
      end
      // fans: 400-clock period, tick 4; divisors 1/4, then 8/1, fan 2 slow
      wr(8'h00, 8'h03);
      wr(8'h05, 8'h60);
      spin = 1'b1;
      repeat (1300) @(negedge clk);
      rd(8'h28, d1);
      chkr(d1, 99, 101);
      rd(8'h29, d2);
      chkr(d2, 24, 26);
      wr(8'h05, 8'h4C);
      half_second = 16'h03E8;
      repeat (6500) @(negedge clk);
      rd(8'h28, d1);
      chkr(d1, 11, 14);
      rdc(8'h29, 8'hFF);
      spin = 1'b0;
      lvl_first = 1'b1;
      wr(8'h05, 8'h43);
      repeat (10) @(negedge clk);
      rdc(8'h28, 8'h01);
      rdc(8'h29, 8'h00);
      // formats: 9-bit, 12-bit, negative
      conv(12'h19E);
      rdc(8'h27, 8'h19);
      rdc(8'h06, 8'h80);
      wr(8'h06, 8'h08);
      conv(12'h19A);
      rdc(8'h27, 8'h19);
      rdc(8'h06, 8'hA8);
      conv(12'hE70);
      rdc(8'h27, 8'hE7);
      // default interrupt mode
      conv(12'h330);
      chk1(int_out_r, 1'b1);
      rd2(d1, d2);
      chk8(d1, 8'h40);
      chk1(int_out_r, 1'b0);
      conv(12'h300);
      chk1(int_out_r, 1'b1);
      conv(12'h2C0);
      chk1(int_out_r, 1'b0);
      // one-time interrupt mode
      wr(8'h06, 8'h0A);
      conv(12'h330);
      chk1(int_out_r, 1'b1);
      rd2(d1, d2);
      chk8(d1, 8'h40);
      conv(12'h300);
      chk1(int_out_r, 1'b0);
      conv(12'h2C0);
      conv(12'h330);
      chk1(int_out_r, 1'b1);
      // clear bit halts loop, keeps status
      wr(8'h00, 8'h0B);
      chk1(int_out_r, 1'b0);
      rdc(8'h01, 8'h40);
      conv(12'h100);
      rdc(8'h27, 8'h33);
      wr(8'h00, 8'h03);
      // overtemp pin, comparator then one-time
      wr(8'h06, 8'h08);
      conv(12'h3D0);
      chk1(pin_oe, 1'b1);
      chk1(pin_o, 1'b0);
      conv(12'h3C0);
      chk1(pin_oe, 1'b1);
      conv(12'h3B0);
      chk1(pin_oe, 1'b0);
      wr(8'h06, 8'h0C);
      conv(12'h3D0);
      conv(12'h3B0);
      chk1(pin_oe, 1'b1);
      rd2(d1, d2);
      chk8(d2, 8'h20);
      chk1(pin_oe, 1'b0);
      wrap_up();
   end
endmodule
